// file: include/rrs_consts.vh
// Constants of the reset release sequencer
`ifndef RRS_CONSTS_VH
`define RRS_CONSTS_VH

// ----------------------------------------
// Release delays, in clock periods
// ----------------------------------------
`define RRS_POR_EXT_CYCLES 7'h40
`define RRS_SYNC_RST_CYCLES 7'h03
`define RRS_CLKGEN_CYCLES 7'h20
`define RRS_PERIP_CYCLES 7'h20
`define RRS_CORE_CYCLES 7'h20

// ----------------------------------------
// Counter width for every extender
// ----------------------------------------
`define RRS_CNT_W 7

// ----------------------------------------
// Reset cause vector bit positions
// ----------------------------------------
`define RRS_CAUSE_POR 0
`define RRS_CAUSE_EXT 1
`define RRS_CAUSE_SW 2
`define RRS_CAUSE_WDT_TO 3
`define RRS_CAUSE_WDT_LOR 4
`define RRS_CAUSE_W 5
`define RRS_CAUSE_RST 5'h01

// ----------------------------------------
// Start-up phase codes, one-hot
// ----------------------------------------
`define RRS_PH_W 5
`define RRS_PH_COMB 5'h01
`define RRS_PH_CLKGEN 5'h02
`define RRS_PH_PERIP 5'h04
`define RRS_PH_CORE 5'h08
`define RRS_PH_RUN 5'h10

`endif

// file: hw/rrs_async_sync.v
// Reset synchroniser: asserts at once, releases after two clock edges
module rrs_async_sync (
    input wire clk_i,
    input wire raw_rst_i,
    output wire rst_o
);
    reg meta_q;
    reg hold_q;

    always @(posedge clk_i or posedge raw_rst_i) begin
        if (raw_rst_i) begin
            meta_q <= 1'b1;
            hold_q <= 1'b1;
        end else begin
            meta_q <= 1'b0;
            hold_q <= meta_q;
        end
    end

    // Raw level forces the output so assertion needs no clock
    assign rst_o = hold_q | raw_rst_i;
endmodule

// file: hw/rrs_extender.v
// Reset extender: holds its output until N enabled edges after its input falls
`include "rrs_consts.vh"
module rrs_extender #(
    parameter [`RRS_CNT_W-1:0] COUNT = 7'h20
) (
    input wire clk_i,
    input wire rst_i,
    input wire tick_i,
    output wire rst_o
);
    reg [`RRS_CNT_W-1:0] cnt_q;
    reg done_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 7'h00;
            done_q <= 1'b0;
        end else if (tick_i && !done_q) begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == COUNT - 7'h01) begin
                done_q <= 1'b1;
            end
        end
    end

    // Input assertion reaches the output in the same cycle
    assign rst_o = rst_i | ~done_q;
endmodule

// file: hw/rrs_reset_release_sequencer.v
// Reset release sequencer of the system integration module
//
// Contract
// - Five reset causes: pin and power-on asynchronous; software, watchdog timeout, lost reference synchronous.
// - Software reset is produced here when the integration control register is written with its software reset bit set.
// - Test-port reset follows power-on reset only.
// - Stretched power-on reset stays on 64 oscillator cycles after synchronised power-on falls.
// - Combined reset is OR of stretched power-on, pin, watchdog, software; holds everything else.
// - Control register, synchronous reset generator, clock-gen extender run only after combined release.
// - Software and watchdog reset logic held until three oscillator cycles after combined release.
// - Clock-generation reset releases 32 oscillator cycles after combined reset release.
// - Clock-generation reset releases synchronously to the oscillator clock to avoid skew.
// - Peripheral reset releases 32 system clock cycles after clock-generation reset.
// - Peripheral and core logic stay clocked while held in reset between clock-generation release and peripheral release.
// - Core reset releases 32 system clock cycles after peripheral reset.
// - Peripheral and core resets release on the delayed system clock falling edge tick.
// - Code execution is allowed only after core reset release, ending start-up.
// - Power-on and combined delay counters run on the oscillator clock.
// - Common system clock; timers and PWM may take the 3X clock only.
// - Converter standby and conversion clocks are not produced here.
// - No interrupt requests are produced.
`include "rrs_consts.vh"
module rrs_reset_release_sequencer (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire por_raw_i,
    input wire ext_rst_n_i,
    input wire ctrl_wr_i,
    input wire ctrl_sw_rst_i,
    input wire wdt_timeout_i,
    input wire wdt_lost_ref_i,
    input wire sys_tick_i,
    input wire sys_fall_tick_i,
    input wire pll_selected_i,
    input wire timer_a_fast_req_i,
    input wire timer_b_fast_req_i,
    input wire pwm_fast_req_i,
    output wire test_port_rst_o,
    output wire ext_por_rst_o,
    output wire combined_rst_o,
    output wire sync_rst_o,
    output wire clock_generation_reset_o,
    output wire peripheral_reset_o,
    output wire core_rst_o,
    output wire core_run_o,
    output wire perip_clk_en_o,
    output reg timer_a_fast_o,
    output reg timer_b_fast_o,
    output reg pwm_fast_o,
    output reg [`RRS_CAUSE_W-1:0] reset_cause_o,
    output reg [`RRS_PH_W-1:0] phase_o
);

    // ----------------------------------------
    // Asynchronous sources
    // ----------------------------------------
    wire por_rst;
    wire ext_rst;
    wire ext_raw;

    // Pin level is active low; both sources assert at once and release
    // two oscillator edges after their raw level falls
    assign ext_raw = ~ext_rst_n_i;

    rrs_async_sync u_por_sync (
        .clk_i(core_clk_i),
        .raw_rst_i(por_raw_i),
        .rst_o(por_rst)
    );

    rrs_async_sync u_ext_sync (
        .clk_i(core_clk_i),
        .raw_rst_i(ext_raw),
        .rst_o(ext_rst)
    );

    // Test port reset driven by power-on only
    assign test_port_rst_o = por_rst;

    // ----------------------------------------
    // Power-on extender on the oscillator clock
    // ----------------------------------------
    wire ext_por_rst;
    wire por_ext_clr;

    // A system reset restarts the stretch as a power-on would
    assign por_ext_clr = por_rst | sys_rst_i;

    rrs_extender #(
        .COUNT(`RRS_POR_EXT_CYCLES)
    ) u_por_ext (
        .clk_i(core_clk_i),
        .rst_i(por_ext_clr),
        .tick_i(1'b1),
        .rst_o(ext_por_rst)
    );

    assign ext_por_rst_o = ext_por_rst;

    // ----------------------------------------
    // Synchronous sources and combined reset
    // ----------------------------------------
    reg sw_rst_q;
    reg wdt_to_q;
    reg wdt_lor_q;
    wire sync_rst;
    wire combined_rst;
    wire ctrl_ok;

    // Synchronous sources hold the combined reset until the
    // synchronous reset generator clears them
    assign combined_rst = ext_por_rst | ext_rst | sw_rst_q | wdt_to_q | wdt_lor_q;
    assign combined_rst_o = combined_rst;

    // Control register accepted only once combined reset is gone
    assign ctrl_ok = ~combined_rst;

    // Each source flop sits in the synchronous reset, so a request that
    // meets the clearing reset is dropped rather than re-arming the chain
    always @(posedge core_clk_i) begin
        if (sync_rst) begin
            sw_rst_q <= 1'b0;
        end else if (ctrl_ok && ctrl_wr_i && ctrl_sw_rst_i) begin
            sw_rst_q <= 1'b1;
        end
    end

    always @(posedge core_clk_i) begin
        if (sync_rst) begin
            wdt_to_q <= 1'b0;
        end else if (wdt_timeout_i) begin
            wdt_to_q <= 1'b1;
        end
    end

    always @(posedge core_clk_i) begin
        if (sync_rst) begin
            wdt_lor_q <= 1'b0;
        end else if (wdt_lost_ref_i) begin
            wdt_lor_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Synchronous reset generator
    // ----------------------------------------
    rrs_extender #(
        .COUNT(`RRS_SYNC_RST_CYCLES)
    ) u_sync_gen (
        .clk_i(core_clk_i),
        .rst_i(combined_rst),
        .tick_i(1'b1),
        .rst_o(sync_rst)
    );

    assign sync_rst_o = sync_rst;

    // ----------------------------------------
    // Clock-generation reset extender
    // ----------------------------------------
    wire clock_generation_reset;

    // Registered release on the oscillator clock keeps it free of skew
    rrs_extender #(
        .COUNT(`RRS_CLKGEN_CYCLES)
    ) u_clkgen_ext (
        .clk_i(core_clk_i),
        .rst_i(combined_rst),
        .tick_i(1'b1),
        .rst_o(clock_generation_reset)
    );

    assign clock_generation_reset_o = clock_generation_reset;

    // ----------------------------------------
    // Peripheral and core reset extenders
    // ----------------------------------------
    wire perip_cnt_rst;
    wire core_cnt_rst;
    wire perip_release;
    wire core_release;
    reg peripheral_reset_q;
    reg core_rst_q;

    // Count system clock periods, release only on a falling-edge tick
    rrs_extender #(
        .COUNT(`RRS_PERIP_CYCLES)
    ) u_perip_ext (
        .clk_i(core_clk_i),
        .rst_i(clock_generation_reset),
        .tick_i(sys_tick_i),
        .rst_o(perip_cnt_rst)
    );

    // Core counter restarts from the registered peripheral reset; the
    // one-cycle lag is covered by the combinational OR on the core output
    rrs_extender #(
        .COUNT(`RRS_CORE_CYCLES)
    ) u_core_ext (
        .clk_i(core_clk_i),
        .rst_i(peripheral_reset_q),
        .tick_i(sys_tick_i),
        .rst_o(core_cnt_rst)
    );

    assign perip_release = ~perip_cnt_rst & sys_fall_tick_i;
    assign core_release = ~core_cnt_rst & sys_fall_tick_i;

    always @(posedge core_clk_i) begin
        if (clock_generation_reset) begin
            peripheral_reset_q <= 1'b1;
        end else if (perip_release) begin
            peripheral_reset_q <= 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (peripheral_reset_q) begin
            core_rst_q <= 1'b1;
        end else if (core_release) begin
            core_rst_q <= 1'b0;
        end
    end

    // Assertion of an upstream reset is seen without waiting
    assign peripheral_reset_o = peripheral_reset_q | clock_generation_reset;
    assign core_rst_o = core_rst_q | peripheral_reset_o;
    assign core_run_o = ~core_rst_o;

    // Peripheral and core clocks run as soon as clock generation is out
    // of reset, so their synchronous resets are resolved
    assign perip_clk_en_o = ~clock_generation_reset;

    // ----------------------------------------
    // Fast clock option for timers and PWM
    // ----------------------------------------
    // Only the two timers and the PWM may leave the common clock, and
    // only when the PLL provides the 3X rate
    always @(posedge core_clk_i) begin
        if (peripheral_reset_o) begin
            timer_a_fast_o <= 1'b0;
        end else begin
            timer_a_fast_o <= timer_a_fast_req_i & pll_selected_i;
        end
    end

    always @(posedge core_clk_i) begin
        if (peripheral_reset_o) begin
            timer_b_fast_o <= 1'b0;
        end else begin
            timer_b_fast_o <= timer_b_fast_req_i & pll_selected_i;
        end
    end

    always @(posedge core_clk_i) begin
        if (peripheral_reset_o) begin
            pwm_fast_o <= 1'b0;
        end else begin
            pwm_fast_o <= pwm_fast_req_i & pll_selected_i;
        end
    end

    // Converter standby and conversion clocks have no output here
    // No interrupt output exists on this block

    // ----------------------------------------
    // Reset cause record
    // ----------------------------------------
    wire cause_clr;

    // Power-on clears the record; the other causes accumulate
    assign cause_clr = sys_rst_i | por_rst;

    // A pin reset is logged while its synchronised level is held
    always @(posedge core_clk_i) begin
        if (cause_clr) begin
            reset_cause_o <= `RRS_CAUSE_RST;
        end else begin
            if (ext_rst) begin
                reset_cause_o[`RRS_CAUSE_EXT] <= 1'b1;
            end
            if (sw_rst_q) begin
                reset_cause_o[`RRS_CAUSE_SW] <= 1'b1;
            end
            if (wdt_to_q) begin
                reset_cause_o[`RRS_CAUSE_WDT_TO] <= 1'b1;
            end
            if (wdt_lor_q) begin
                reset_cause_o[`RRS_CAUSE_WDT_LOR] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Start-up phase tracker
    // ----------------------------------------
    reg [`RRS_PH_W-1:0] phase_d;

    // Steps once per stage release; a new combined reset sends it back
    // to the first stage from wherever it stands
    always @* begin
        phase_d = phase_o;
        case (phase_o)
            `RRS_PH_COMB: begin
                if (!combined_rst) begin
                    phase_d = `RRS_PH_CLKGEN;
                end
            end
            `RRS_PH_CLKGEN: begin
                if (!clock_generation_reset) begin
                    phase_d = `RRS_PH_PERIP;
                end
            end
            `RRS_PH_PERIP: begin
                if (!peripheral_reset_o) begin
                    phase_d = `RRS_PH_CORE;
                end
            end
            `RRS_PH_CORE: begin
                if (!core_rst_o) begin
                    phase_d = `RRS_PH_RUN;
                end
            end
            `RRS_PH_RUN: begin
                phase_d = `RRS_PH_RUN;
            end
            default: begin
                phase_d = `RRS_PH_COMB;
            end
        endcase
        if (combined_rst) begin
            phase_d = `RRS_PH_COMB;
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase_o <= `RRS_PH_COMB;
        end else begin
            phase_o <= phase_d;
        end
    end

endmodule

// file: verification/rrs_seq_chk.sv
// Assertion checker for the reset release sequencer
`include "rrs_consts.vh"
module rrs_seq_chk (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire por_raw_i,
    input wire ctrl_wr_i,
    input wire ctrl_sw_rst_i,
    input wire wdt_timeout_i,
    input wire sys_tick_i,
    input wire sys_fall_tick_i,
    input wire pll_selected_i,
    input wire timer_a_fast_req_i,
    input wire test_port_rst_o,
    input wire ext_por_rst_o,
    input wire combined_rst_o,
    input wire sync_rst_o,
    input wire clock_generation_reset_o,
    input wire peripheral_reset_o,
    input wire core_rst_o,
    input wire core_run_o,
    input wire perip_clk_en_o,
    input wire timer_a_fast_o,
    input wire [`RRS_CAUSE_W-1:0] reset_cause_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // Tick counters
    // ----------------
    reg [6:0] pc_q;
    reg [6:0] cc_q;
    always @(posedge core_clk_i) begin
        if (sys_rst_i || clock_generation_reset_o)
            pc_q <= 7'h00;
        else if (sys_tick_i && peripheral_reset_o && pc_q < 7'h40)
            pc_q <= pc_q + 7'h01;
        if (sys_rst_i || peripheral_reset_o)
            cc_q <= 7'h00;
        else if (sys_tick_i && core_rst_o && cc_q < 7'h40)
            cc_q <= cc_q + 7'h01;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    comb_or_a: assert property (ext_por_rst_o |-> combined_rst_o && clock_generation_reset_o && core_rst_o)
        else $error("combined reset not held");
    test_port_a: assert property (por_raw_i |-> test_port_rst_o && ext_por_rst_o)
        else $error("power-on not passed at once");
    por_hold_a: assert property ($fell(test_port_rst_o) |-> ##62 ext_por_rst_o ##[1:3] !ext_por_rst_o)
        else $error("power-on stretch wrong");
    sync_gap_a: assert property ($fell(combined_rst_o) |-> ##2 sync_rst_o ##1 !sync_rst_o)
        else $error("sync reset release wrong");
    clkgen_gap_a: assert property ($fell(combined_rst_o) |-> ##31 clock_generation_reset_o ##1 !clock_generation_reset_o)
        else $error("clkgen release wrong");
    perip_rel_a: assert property ($fell(peripheral_reset_o) |-> $past(sys_fall_tick_i) && pc_q >= 7'h20)
        else $error("peripheral release early");
    core_rel_a: assert property ($fell(core_rst_o) |-> $past(sys_fall_tick_i) && cc_q >= 7'h20)
        else $error("core release early");
    core_late_a: assert property ($fell(clock_generation_reset_o) |-> ##[1:300] !core_rst_o)
        else $error("core release late");
    run_gate_a: assert property (core_run_o |-> !peripheral_reset_o && !clock_generation_reset_o && !combined_rst_o)
        else $error("core runs in reset");
    sw_req_a: assert property (ctrl_wr_i && ctrl_sw_rst_i && !combined_rst_o && !sync_rst_o
        |=> combined_rst_o ##1 reset_cause_o[`RRS_CAUSE_SW])
        else $error("software reset missed");
    wdt_req_a: assert property (wdt_timeout_i && !sync_rst_o
        |=> combined_rst_o ##1 reset_cause_o[`RRS_CAUSE_WDT_TO])
        else $error("watchdog reset missed");
    fast_sel_a: assert property (!peripheral_reset_o && !$past(peripheral_reset_o)
        |-> timer_a_fast_o == $past(timer_a_fast_req_i && pll_selected_i))
        else $error("fast clock select wrong");
    clk_en_a: assert property (peripheral_reset_o && !clock_generation_reset_o |-> perip_clk_en_o)
        else $error("peripheral clock off in reset");
    cover property ($fell(core_rst_o));
    cover property ($rose(reset_cause_o[`RRS_CAUSE_WDT_TO]));
    cover property ($rose(timer_a_fast_o));
endmodule
bind rrs_reset_release_sequencer rrs_seq_chk chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .por_raw_i(por_raw_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_sw_rst_i(ctrl_sw_rst_i), .wdt_timeout_i(wdt_timeout_i),
    .sys_tick_i(sys_tick_i), .sys_fall_tick_i(sys_fall_tick_i), .pll_selected_i(pll_selected_i),
    .timer_a_fast_req_i(timer_a_fast_req_i), .test_port_rst_o(test_port_rst_o), .ext_por_rst_o(ext_por_rst_o),
    .combined_rst_o(combined_rst_o), .sync_rst_o(sync_rst_o), .clock_generation_reset_o(clock_generation_reset_o),
    .peripheral_reset_o(peripheral_reset_o), .core_rst_o(core_rst_o), .core_run_o(core_run_o),
    .timer_a_fast_o(timer_a_fast_o), .perip_clk_en_o(perip_clk_en_o), .reset_cause_o(reset_cause_o));

// file: verification/rrs_clk_model.sv
// Clock generator model: system clock ticks only while clocks are enabled
module rrs_clk_model #(
    parameter DIV = 2
) (
    input wire core_clk_i,
    input wire run_i,
    output reg sys_tick_o,
    output reg sys_fall_tick_o
);
    timeunit 1ns;
    timeprecision 1ns;
    integer cnt = 0;
    initial begin
        sys_tick_o = 1'h0;
        sys_fall_tick_o = 1'h0;
    end
    // Keeps ticking once enabled, so logic held in reset still sees clocks
    always @(posedge core_clk_i) begin
        cnt <= run_i ? (cnt + 1) % DIV : 0;
        sys_tick_o <= run_i && cnt == 0;
        sys_fall_tick_o <= run_i && cnt == DIV / 2;
    end
endmodule

// file: verification/reset_release_sequencer_test.sv
// Self-checking bench for the reset release sequencer
`include "rrs_consts.vh"
module reset_release_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg core_clk_i = 1'h0;
    reg sys_rst_i = 1'h1;
    reg por_raw_i = 1'h1;
    reg ext_rst_n_i = 1'h1;
    reg ctrl_wr_i = 1'h0;
    reg ctrl_sw_rst_i = 1'h0;
    reg wdt_timeout_i = 1'h0;
    reg wdt_lost_ref_i = 1'h0;
    reg pll_selected_i = 1'h0;
    reg [2:0] fast_req = 3'h0;
    wire sys_tick_i, sys_fall_tick_i, test_port_rst_o, ext_por_rst_o, combined_rst_o, sync_rst_o;
    wire clock_generation_reset_o, peripheral_reset_o, core_rst_o, core_run_o, perip_clk_en_o;
    wire timer_a_fast_o, timer_b_fast_o, pwm_fast_o;
    wire [`RRS_CAUSE_W-1:0] reset_cause_o;
    wire [`RRS_PH_W-1:0] phase_o;
    integer mismatches = 0;
    integer checked = 0;
    integer t_comb, t_sync, t_clk, t_perip, t_core, n, i;
    always #50 core_clk_i = ~core_clk_i;
    rrs_reset_release_sequencer uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .por_raw_i(por_raw_i),
        .ext_rst_n_i(ext_rst_n_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_sw_rst_i(ctrl_sw_rst_i),
        .wdt_timeout_i(wdt_timeout_i), .wdt_lost_ref_i(wdt_lost_ref_i), .sys_tick_i(sys_tick_i),
        .sys_fall_tick_i(sys_fall_tick_i), .pll_selected_i(pll_selected_i), .timer_a_fast_req_i(fast_req[2]),
        .timer_b_fast_req_i(fast_req[1]), .pwm_fast_req_i(fast_req[0]), .test_port_rst_o(test_port_rst_o),
        .ext_por_rst_o(ext_por_rst_o), .combined_rst_o(combined_rst_o), .sync_rst_o(sync_rst_o),
        .clock_generation_reset_o(clock_generation_reset_o), .peripheral_reset_o(peripheral_reset_o), .core_rst_o(core_rst_o),
        .core_run_o(core_run_o), .perip_clk_en_o(perip_clk_en_o), .timer_a_fast_o(timer_a_fast_o),
        .timer_b_fast_o(timer_b_fast_o), .pwm_fast_o(pwm_fast_o), .reset_cause_o(reset_cause_o),
        .phase_o(phase_o));
    rrs_clk_model #(.DIV(2)) clkgen (.core_clk_i(core_clk_i), .run_i(perip_clk_en_o),
        .sys_tick_o(sys_tick_i), .sys_fall_tick_o(sys_fall_tick_i));
    // ----------------
    // Checking tasks
    // ----------------
    task end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Records the cycle at which each reset stage first reads low
    task watch;
        t_comb = -1;
        t_sync = -1;
        t_clk = -1;
        t_perip = -1;
        t_core = -1;
        for (n = 1; n < 600 && core_run_o !== 1'h1; n = n + 1) begin
            @(negedge core_clk_i);
            if (t_comb < 0 && combined_rst_o === 1'h0) t_comb = n;
            if (t_sync < 0 && sync_rst_o === 1'h0) t_sync = n;
            if (t_clk < 0 && clock_generation_reset_o === 1'h0) t_clk = n;
            if (t_perip < 0 && peripheral_reset_o === 1'h0) t_perip = n;
            if (t_core < 0 && core_rst_o === 1'h0) t_core = n;
        end
        if (core_run_o !== 1'h1) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    endtask
    // One reset cause (index 5 is a system reset), then the full release sequence
    task cause_run(input integer idx);
        @(negedge core_clk_i);
        sys_rst_i = (idx == 5);
        por_raw_i = (idx == 0);
        ext_rst_n_i = (idx != 1);
        ctrl_wr_i = (idx == 2);
        ctrl_sw_rst_i = (idx == 2);
        wdt_timeout_i = (idx == 3);
        wdt_lost_ref_i = (idx == 4);
        @(negedge core_clk_i);
        check("test_port", idx == 0, test_port_rst_o);
        check("combined", 1, combined_rst_o);
        check("core_run", 0, core_run_o);
        check("perip_clk_en", 0, perip_clk_en_o);
        sys_rst_i = 1'h0;
        por_raw_i = 1'h0;
        ext_rst_n_i = 1'h1;
        ctrl_wr_i = 1'h0;
        ctrl_sw_rst_i = 1'h0;
        wdt_timeout_i = 1'h0;
        wdt_lost_ref_i = 1'h0;
        watch;
        if (idx == 0) check("por_stretch", 66, t_comb);
        if (idx == 5) check("rst_stretch", 64, t_comb);
        check("sync_gap", 3, t_sync - t_comb);
        check("clkgen_gap", 32, t_clk - t_comb);
        check("perip_gap", 1, t_perip - t_clk >= 64 && t_perip - t_clk <= 66);
        check("core_gap", 1, t_core - t_perip >= 64 && t_core - t_perip <= 66);
        check("perip_clk_on", 1, perip_clk_en_o);
        if (idx < 5) check("cause", 1, reset_cause_o[idx]);
        if (idx == 5) check("cause_clear", `RRS_CAUSE_RST, reset_cause_o);
        // Phase register follows the core release one cycle later
        @(negedge core_clk_i);
        check("phase", `RRS_PH_RUN, phase_o);
    endtask
    // Fast clocks need the PLL; a write without the reset bit does nothing
    task fast_clock;
        @(negedge core_clk_i);
        fast_req = 3'h7;
        ctrl_wr_i = 1'h1;
        @(negedge core_clk_i);
        ctrl_wr_i = 1'h0;
        @(negedge core_clk_i);
        check("fast_nopll", 0, {timer_a_fast_o, timer_b_fast_o, pwm_fast_o});
        check("no_sw_reset", 0, combined_rst_o);
        pll_selected_i = 1'h1;
        repeat (2) @(negedge core_clk_i);
        check("fast_pll", 3'h7, {timer_a_fast_o, timer_b_fast_o, pwm_fast_o});
    endtask
    initial begin
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'h0;
        for (i = 0; i <= `RRS_CAUSE_W; i = i + 1)
            cause_run(i);
        fast_clock;
        end_of_test;
    end
endmodule
